// File: inc/vic_defines.svh
/*
 Constants of the vectored interrupt controller: register addresses, field
 positions, reset values, vector table and cycle counts.
 Assumes it is included by its bare name from the controller's files.
*/
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// register addresses (8-bit special function space)
`define VIC_ADDR_TIMER_CTRL 8'h88
`define VIC_ADDR_IRQ_ENABLE 8'hA8
`define VIC_ADDR_PRIORITY 8'hB8
`define VIC_ADDR_EXT_ENABLE 8'hE6
`define VIC_ADDR_EXT_PRIORITY 8'hF6
`define VIC_ADDR_SERVICE 8'hD1
`define VIC_ADDR_IRQ_STATUS 8'hD2
`define VIC_ADDR_IRQ_MASK 8'hD3

// reset values
`define VIC_RST_TIMER_CTRL 8'h00
`define VIC_RST_IRQ_ENABLE 8'h00
`define VIC_RST_PRIORITY 8'h80
`define VIC_RST_EXT 8'h00
`define VIC_RST_IRQ_BITS 2'h0

// field positions
`define VIC_GLOBAL_EN_BIT 7
`define VIC_PRIO_UNUSED_BIT 7
`define VIC_EXT0_PEND_BIT 1
`define VIC_EXT1_PEND_BIT 3
`define VIC_TMR0_FLAG_BIT 5
`define VIC_TMR1_FLAG_BIT 7
`define VIC_EVT_CALL_BIT 0
`define VIC_EVT_PREEMPT_BIT 1

// priority-order positions and vectors
`define VIC_NUM_POS 15
`define VIC_BASE_POS_WIDTH 7
`define VIC_EXT_FIRST_POS 7
`define VIC_RSVD_MASK 15'h2100
`define VIC_POS_EXT0 4'h0
`define VIC_POS_TMR0 4'h1
`define VIC_POS_EXT1 4'h2
`define VIC_POS_TMR1 4'h3
`define VIC_RESET_VECTOR 16'h0000
`define VIC_VEC_BASE 16'h0003

// response timing in system clocks at 100 MHz (10 ns)
`define VIC_CLK_PERIOD_NS 10
`define VIC_DETECT_CYC 1
`define VIC_LONG_CALL_CYC 4
`define VIC_RETURN_FROM_INTERRUPT_CYC 5
`define VIC_DIV_CYC 8
`define VIC_RESP_MIN_CYC (`VIC_DETECT_CYC + `VIC_LONG_CALL_CYC)
`define VIC_RESP_MAX_CYC (`VIC_DETECT_CYC + `VIC_RETURN_FROM_INTERRUPT_CYC + `VIC_DIV_CYC + `VIC_LONG_CALL_CYC)

`endif

// File: inc/vic_pkg.sv
/*
 Types of the vectored interrupt controller.
 Assumes nothing of its surroundings; users name everything with vic_pkg::.
*/
package vic_pkg;

   // call handshake towards the core
   typedef enum logic {
      ST_IDLE,
      ST_CALL
   } call_state_t;

   typedef logic [14:0] src_vec_t;

endpackage : vic_pkg

// File: logic/vic_prio_encoder.sv
/*
 Fixed-order priority encoder: the highest level wins, then the lowest
 priority-order position.
 Assumes requests are already gated by enables and registered by the caller.
*/
`timescale 1ns/1ps
`include "vic_defines.svh"

module vic_prio_encoder (
   input wire vic_pkg::src_vec_t req_i,
   input wire vic_pkg::src_vec_t high_i,
   output logic valid_o,
   output logic [3:0] pos_o,
   output logic high_o
);

   logic hi_found;
   logic lo_found;
   logic [3:0] hi_pos;
   logic [3:0] lo_pos;

   // scan downward so the last hit is the lowest position
   always_comb begin
      hi_found = 1'b0;
      lo_found = 1'b0;
      hi_pos = 4'h0;
      lo_pos = 4'h0;
      for (int i = `VIC_NUM_POS - 1; i >= 0; i--) begin
         if (req_i[i] && high_i[i]) begin
            hi_found = 1'b1;
            hi_pos = 4'(i);
         end
         if (req_i[i] && !high_i[i]) begin
            lo_found = 1'b1;
            lo_pos = 4'(i);
         end
      end
   end

   // a high-level request always beats any low-level one
   always_comb begin
      valid_o = hi_found | lo_found;
      high_o = hi_found;
      pos_o = hi_found ? hi_pos : lo_pos;
   end

endmodule : vic_prio_encoder

// File: logic/vectored_interrupt_controller.sv
/*
 Vectored interrupt controller: pending flags, enables, two priority levels,
 fixed-order arbitration and the long-call request towards the core.
 Assumes the core pulses instr_done_i at each instruction boundary, pulses
 return_from_interrupt_i together with instr_done_i at the end of a return, and pulses
 call_ack_i only while call_req_o is high, when the long call starts.
*/
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "vic_defines.svh"

// Functional notes
// - Pending flags are sampled and priority decoded every clock, one clock to detect.
// - Fastest response is 5 clocks: one to detect plus 4 for the long call.
// - A request pending during a return waits for one more instruction before the call.
// - Worst case without competing service is 18 clocks: 1 + 5 return + 8 divide + 4 call.
// - An active routine of equal or higher level holds a new request until it returns.
// - Reset vectors to 0x0000, cannot be masked and outranks every source.
// - Vectors start at 0x0003 and step by eight per position; lower positions win ties.
// - Positions 8 and 13 are reserved with no flag, enable or priority.
// - External 0/1 and timer 0/1 flags are cleared by hardware when the core vectors.
// - Sources with several flags raise one request when any of them is set.
// - Positions 0-6 enable in the enable register bits 0-6; 7 up map to extended bits.
// - Timer 3 and comparator flags are reachable only by byte-wide access.
// - The enable register sits at 0xA8, bit addressable, with the global enable in bit 7.
// - A high-level request preempts a low-level routine; a high routine is never preempted.
// - A flag still set after a return raises a new request after the next instruction.
module vectored_interrupt_controller (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic bit_wr_i,
   output logic [7:0] rdata_o,
   input wire logic ext0_event_i,
   input wire logic ext1_event_i,
   input wire logic timer0_overflow_i,
   input wire logic timer1_overflow_i,
   input wire logic uart_rx_flag_i,
   input wire logic uart_tx_flag_i,
   input wire logic timer2_high_flag_i,
   input wire logic timer2_low_flag_i,
   input wire logic serial_periph_done_flag_i,
   input wire logic write_collision_flag_i,
   input wire logic mode_fault_flag_i,
   input wire logic rx_overrun_flag_i,
   input wire logic two_wire_flag_i,
   input wire logic adc_window_flag_i,
   input wire logic adc_done_flag_i,
   input wire logic counter_array_overflow_flag_i,
   input wire logic [2:0] capture_compare_flags_i,
   input wire logic comparator_fall_flag_i,
   input wire logic comparator_rise_flag_i,
   input wire logic timer3_high_flag_i,
   input wire logic timer3_low_flag_i,
   input wire logic instr_done_i,
   input wire logic return_from_interrupt_i,
   input wire logic call_ack_i,
   output logic call_req_o,
   output logic [15:0] vector_o,
   output logic call_high_o,
   output logic irq_o
);

   logic [7:0] timer_control_reg;
   logic [7:0] interrupt_enable_reg;
   logic [7:0] priority_reg;
   logic [7:0] extended_enable_reg;
   logic [7:0] extended_priority_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic low_active_reg;
   logic high_active_reg;
   logic [3:0] pos_reg;
   vic_pkg::call_state_t state_reg;
   vic_pkg::src_vec_t pending;
   vic_pkg::src_vec_t enable;
   vic_pkg::src_vec_t high;
   vic_pkg::src_vec_t req_raw;
   vic_pkg::src_vec_t req_reg;
   logic win_valid;
   logic [3:0] win_pos;
   logic win_high;
   logic issue_ok;
   logic issue;
   logic taken;
   logic preempt;
   logic [7:0] timer_control_next;

   // byte write or single-bit write into one register
   function automatic logic [7:0] sfr_update(input logic [7:0] old, input logic byte_hit,
                                             input logic bit_hit, input logic [7:0] wd,
                                             input logic [2:0] idx);
      logic [7:0] v;
      v = old;
      if (byte_hit) begin
         v = wd;
      end else if (bit_hit) begin
         v[idx] = wd[0];
      end
      return v;
   endfunction : sfr_update

   // decode of byte writes and bit writes
   logic wr_timer_control_reg, wr_ie, wr_ip, wr_eie, wr_eip, wr_stat, wr_mask;
   logic bw_timer_control_reg, bw_ie, bw_ip;
   always_comb begin
      wr_timer_control_reg = wr_i && (addr_i == `VIC_ADDR_TIMER_CTRL);
      wr_ie = wr_i && (addr_i == `VIC_ADDR_IRQ_ENABLE);
      wr_ip = wr_i && (addr_i == `VIC_ADDR_PRIORITY);
      wr_eie = wr_i && (addr_i == `VIC_ADDR_EXT_ENABLE);
      wr_eip = wr_i && (addr_i == `VIC_ADDR_EXT_PRIORITY);
      wr_stat = wr_i && (addr_i == `VIC_ADDR_IRQ_STATUS);
      wr_mask = wr_i && (addr_i == `VIC_ADDR_IRQ_MASK);
      // only eight-aligned registers answer bit writes
      bw_timer_control_reg = bit_wr_i && (addr_i[7:3] == `VIC_ADDR_TIMER_CTRL >> 3);
      bw_ie = bit_wr_i && (addr_i[7:3] == `VIC_ADDR_IRQ_ENABLE >> 3);
      bw_ip = bit_wr_i && (addr_i[7:3] == `VIC_ADDR_PRIORITY >> 3);
   end

   // enable and priority registers, software owned
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         interrupt_enable_reg <= `VIC_RST_IRQ_ENABLE;
         priority_reg <= `VIC_RST_PRIORITY;
         extended_enable_reg <= `VIC_RST_EXT;
         extended_priority_reg <= `VIC_RST_EXT;
      end else begin
         interrupt_enable_reg <= sfr_update(interrupt_enable_reg, wr_ie, bw_ie, wdata_i,
                                            addr_i[2:0]);
         priority_reg <= sfr_update(priority_reg, wr_ip, bw_ip, wdata_i, addr_i[2:0]);
         // unused top priority bit stays at one
         priority_reg[`VIC_PRIO_UNUSED_BIT] <= 1'b1;
         extended_enable_reg <= sfr_update(extended_enable_reg, wr_eie, 1'b0, wdata_i, 3'h0);
         extended_priority_reg <= sfr_update(extended_priority_reg, wr_eip, 1'b0, wdata_i,
                                             3'h0);
      end
   end

   // timer control: software value, then vectoring clear, then new events on top
   always_comb begin
      timer_control_next = sfr_update(timer_control_reg, wr_timer_control_reg, bw_timer_control_reg, wdata_i,
                                      addr_i[2:0]);
      // hardware clear when the core vectors
      if (taken && pos_reg == `VIC_POS_EXT0) begin
         timer_control_next[`VIC_EXT0_PEND_BIT] = 1'b0;
      end
      if (taken && pos_reg == `VIC_POS_TMR0) begin
         timer_control_next[`VIC_TMR0_FLAG_BIT] = 1'b0;
      end
      if (taken && pos_reg == `VIC_POS_EXT1) begin
         timer_control_next[`VIC_EXT1_PEND_BIT] = 1'b0;
      end
      if (taken && pos_reg == `VIC_POS_TMR1) begin
         timer_control_next[`VIC_TMR1_FLAG_BIT] = 1'b0;
      end
      // an event in the clearing cycle must not be lost
      if (ext0_event_i) begin
         timer_control_next[`VIC_EXT0_PEND_BIT] = 1'b1;
      end
      if (ext1_event_i) begin
         timer_control_next[`VIC_EXT1_PEND_BIT] = 1'b1;
      end
      if (timer0_overflow_i) begin
         timer_control_next[`VIC_TMR0_FLAG_BIT] = 1'b1;
      end
      if (timer1_overflow_i) begin
         timer_control_next[`VIC_TMR1_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer_control_reg <= `VIC_RST_TIMER_CTRL;
      end else begin
         timer_control_reg <= timer_control_next;
      end
   end

   // pending vector in priority order
   always_comb begin
      pending[0] = timer_control_reg[`VIC_EXT0_PEND_BIT];
      pending[1] = timer_control_reg[`VIC_TMR0_FLAG_BIT];
      pending[2] = timer_control_reg[`VIC_EXT1_PEND_BIT];
      pending[3] = timer_control_reg[`VIC_TMR1_FLAG_BIT];
      pending[4] = uart_rx_flag_i | uart_tx_flag_i;
      pending[5] = timer2_high_flag_i | timer2_low_flag_i;
      pending[6] = serial_periph_done_flag_i | write_collision_flag_i | mode_fault_flag_i |
                   rx_overrun_flag_i;
      pending[7] = two_wire_flag_i;
      pending[8] = 1'b0;
      pending[9] = adc_window_flag_i;
      pending[10] = adc_done_flag_i;
      pending[11] = counter_array_overflow_flag_i | (|capture_compare_flags_i);
      pending[12] = comparator_fall_flag_i | comparator_rise_flag_i;
      pending[13] = 1'b0;
      pending[14] = timer3_high_flag_i | timer3_low_flag_i;
   end

   genvar p;
   generate
      for (p = 0; p < `VIC_NUM_POS; p++) begin : g_pos
         if (p < `VIC_BASE_POS_WIDTH) begin : g_base
            assign enable[p] = interrupt_enable_reg[p];
            assign high[p] = priority_reg[p];
         end else begin : g_ext
            assign enable[p] = extended_enable_reg[p - `VIC_EXT_FIRST_POS];
            assign high[p] = extended_priority_reg[p - `VIC_EXT_FIRST_POS];
         end
      end
   endgenerate

   // global enable gates all sources; reserved positions never request
   assign req_raw = pending & enable & ~`VIC_RSVD_MASK &
                    {`VIC_NUM_POS{interrupt_enable_reg[`VIC_GLOBAL_EN_BIT]}};

   // sample every clock, one clock of detection
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         req_reg <= '0;
      end else begin
         req_reg <= req_raw;
      end
   end

   // fixed order arbitration among the sampled requests
   vic_prio_encoder u_prio (
      .req_i(req_reg),
      .high_i(high),
      .valid_o(win_valid),
      .pos_o(win_pos),
      .high_o(win_high)
   );

   // equal or higher active level holds the winner off
   assign issue_ok = win_valid && !high_active_reg && (win_high || !low_active_reg);

   // never at the return boundary, so one more instruction runs first
   assign issue = (state_reg == vic_pkg::ST_IDLE) && instr_done_i && !return_from_interrupt_i && issue_ok;
   assign taken = (state_reg == vic_pkg::ST_CALL) && call_ack_i;
   assign preempt = taken && call_high_o && low_active_reg;

   // call handshake; the core spends the long-call cycles after the ack
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= vic_pkg::ST_IDLE;
         call_req_o <= 1'b0;
      end else begin
         case (state_reg)
            vic_pkg::ST_IDLE: begin
               if (issue) begin
                  state_reg <= vic_pkg::ST_CALL;
                  call_req_o <= 1'b1;
               end
            end
            vic_pkg::ST_CALL: begin
               if (call_ack_i) begin
                  state_reg <= vic_pkg::ST_IDLE;
                  call_req_o <= 1'b0;
               end
            end
            default: begin
               state_reg <= vic_pkg::ST_IDLE;
               call_req_o <= 1'b0;
            end
         endcase
      end
   end

   // reset vector while idle; winner latched at the boundary and held
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vector_o <= `VIC_RESET_VECTOR;
         pos_reg <= 4'h0;
         call_high_o <= 1'b0;
      end else if (issue) begin
         vector_o <= `VIC_VEC_BASE + {9'h000, win_pos, 3'h0};
         pos_reg <= win_pos;
         call_high_o <= win_high;
      end else if (taken) begin
         vector_o <= `VIC_RESET_VECTOR;
      end
   end

   // active routine levels; a return closes the innermost one
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_active_reg <= 1'b0;
         high_active_reg <= 1'b0;
      end else if (taken) begin
         if (call_high_o) begin
            high_active_reg <= 1'b1;
         end else begin
            low_active_reg <= 1'b1;
         end
      end else if (return_from_interrupt_i) begin
         if (high_active_reg) begin
            high_active_reg <= 1'b0;
         end else begin
            low_active_reg <= 1'b0;
         end
      end
   end

   // sticky events, write one to clear, a new event beats the clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_status_reg <= `VIC_RST_IRQ_BITS;
         irq_mask_reg <= `VIC_RST_IRQ_BITS;
      end else begin
         irq_status_reg[`VIC_EVT_CALL_BIT] <= taken ||
            (irq_status_reg[`VIC_EVT_CALL_BIT] && !(wr_stat && wdata_i[`VIC_EVT_CALL_BIT]));
         irq_status_reg[`VIC_EVT_PREEMPT_BIT] <= preempt ||
            (irq_status_reg[`VIC_EVT_PREEMPT_BIT] &&
             !(wr_stat && wdata_i[`VIC_EVT_PREEMPT_BIT]));
         if (wr_mask) begin
            irq_mask_reg <= wdata_i[1:0];
         end
      end
   end

   // level interrupt; registered, so it trails the status by one clock
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // read data for one cycle after the strobe, zero otherwise and when unmapped
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 8'h00;
      end else if (!rd_i) begin
         rdata_o <= 8'h00;
      end else if (addr_i == `VIC_ADDR_TIMER_CTRL) begin
         rdata_o <= timer_control_reg;
      end else if (addr_i == `VIC_ADDR_IRQ_ENABLE) begin
         rdata_o <= interrupt_enable_reg;
      end else if (addr_i == `VIC_ADDR_PRIORITY) begin
         rdata_o <= priority_reg;
      end else if (addr_i == `VIC_ADDR_EXT_ENABLE) begin
         rdata_o <= extended_enable_reg;
      end else if (addr_i == `VIC_ADDR_EXT_PRIORITY) begin
         rdata_o <= extended_priority_reg;
      end else if (addr_i == `VIC_ADDR_SERVICE) begin
         rdata_o <= {5'h00, call_req_o, high_active_reg, low_active_reg};
      end else if (addr_i == `VIC_ADDR_IRQ_STATUS) begin
         rdata_o <= {6'h00, irq_status_reg};
      end else if (addr_i == `VIC_ADDR_IRQ_MASK) begin
         rdata_o <= {6'h00, irq_mask_reg};
      end else begin
         rdata_o <= 8'h00;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence s_boundary_win;
      instr_done_i && !return_from_interrupt_i && issue_ok && !call_req_o;
   endsequence

   sequence s_call_held;
      call_req_o && !call_ack_i;
   endsequence

   chk_detect_one_clock: assert property (
      (|req_raw) |=> win_valid)
      else $error("enabled flag not detected after one clock");

   chk_call_needs_detect: assert property (
      $rose(call_req_o) |-> $past(win_valid) && $past(instr_done_i))
      else $error("call raised without a detected request at a boundary");

   chk_no_call_at_return: assert property (
      return_from_interrupt_i |=> !$rose(call_req_o))
      else $error("call raised at a return boundary");

   chk_boundary_issue: assert property (
      s_boundary_win |=> call_req_o && vector_o == `VIC_VEC_BASE + {9'h000, $past(win_pos), 3'h0})
      else $error("eligible request not called at the boundary");

   chk_high_not_preempted: assert property (
      high_active_reg && !return_from_interrupt_i |=> !$rose(call_req_o))
      else $error("call raised while a high routine is active");

   chk_reset_vector_idle: assert property (
      !call_req_o |-> vector_o == `VIC_RESET_VECTOR)
      else $error("vector not at reset address while idle");

   chk_reserved_quiet: assert property (
      (req_reg & `VIC_RSVD_MASK) == '0)
      else $error("reserved position requested");

   chk_hw_flag_clear: assert property (
      taken && pos_reg == `VIC_POS_TMR0 && !timer0_overflow_i |=>
      !timer_control_reg[`VIC_TMR0_FLAG_BIT])
      else $error("timer 0 flag not cleared on vectoring");

   chk_global_gate: assert property (
      !interrupt_enable_reg[`VIC_GLOBAL_EN_BIT] |=> req_reg == '0)
      else $error("request passed with global enable low");

   chk_low_preempt: assert property (
      low_active_reg && !high_active_reg && call_req_o |-> call_high_o)
      else $error("low request called over a low routine");

   chk_vector_stable: assert property (
      s_call_held |=> call_req_o && $stable(vector_o) ##0 $stable(call_high_o))
      else $error("vector changed before the call started");

endmodule : vectored_interrupt_controller

// File: tb/core_model.sv
/*
 Behavioural core: instruction boundaries, returns on demand, long-call acknowledge.
 Assumes the controller's single clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module core_model (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [3:0] gap_i,
   input wire logic return_from_interrupt_req_i,
   input wire logic call_req_i,
   output logic instr_done_o,
   output logic return_from_interrupt_o,
   output logic call_ack_o
);
   logic [3:0] cnt_reg;
   logic rpend_reg;
   // one boundary every gap_i clocks; the ack also waits gap_i so slow cores are covered
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg <= 4'h0;
         instr_done_o <= 1'b0;
         return_from_interrupt_o <= 1'b0;
         call_ack_o <= 1'b0;
         rpend_reg <= 1'b0;
      end else begin
         instr_done_o <= 1'b0;
         return_from_interrupt_o <= 1'b0;
         call_ack_o <= 1'b0;
         cnt_reg <= cnt_reg + 4'h1;
         if (call_req_i && !call_ack_o) begin
            call_ack_o <= (cnt_reg >= gap_i - 4'h1);
         end else if (call_ack_o) begin
            cnt_reg <= 4'h0;
         end else if (cnt_reg >= gap_i - 4'h1) begin
            cnt_reg <= 4'h0;
            instr_done_o <= 1'b1;
            return_from_interrupt_o <= rpend_reg;
            rpend_reg <= 1'b0;
         end
         if (return_from_interrupt_req_i) begin
            rpend_reg <= 1'b1;
         end
      end
   end
endmodule : core_model

// File: tb/tb_top.sv
/*
 Self-checking bench of the interrupt controller with a behavioural core.
 Assumes one 100 MHz clock and the register map of the controller's defines.
*/
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic bw = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [14:0] prim = 15'h0;
   logic [14:0] sec = 15'h0;
   logic [3:0] gap = 4'h1;
   logic return_from_interrupt_req = 1'b0;
   logic [7:0] rdata;
   logic [15:0] vec;
   logic done, return_from_interrupt, ack, creq, chigh, irq;
   logic [7:0] ra [9] = '{8'h88, 8'hA8, 8'hB8, 8'hE6, 8'hF6, 8'hD1, 8'hD2, 8'hD3, 8'h00};
   int err_count = 0;
   int checked = 0;
   int nb, p, s, i;
   // free-running system clock
   always #5 clk_i = ~clk_i;
   vectored_interrupt_controller i_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .bit_wr_i(bw), .rdata_o(rdata), .ext0_event_i(ev[0]), .ext1_event_i(ev[2]),
      .timer0_overflow_i(ev[1]), .timer1_overflow_i(ev[3]), .uart_rx_flag_i(prim[4]),
      .uart_tx_flag_i(sec[4]), .timer2_high_flag_i(prim[5]), .timer2_low_flag_i(sec[5]),
      .serial_periph_done_flag_i(prim[6]), .write_collision_flag_i(sec[6]),
      .mode_fault_flag_i(sec[6]), .rx_overrun_flag_i(sec[6]), .two_wire_flag_i(prim[7]),
      .adc_window_flag_i(prim[9]), .adc_done_flag_i(prim[10]),
      .counter_array_overflow_flag_i(prim[11]), .capture_compare_flags_i({3{sec[11]}}),
      .comparator_fall_flag_i(prim[12]), .comparator_rise_flag_i(sec[12]),
      .timer3_high_flag_i(prim[14]), .timer3_low_flag_i(sec[14]), .instr_done_i(done),
      .return_from_interrupt_i(return_from_interrupt), .call_ack_i(ack), .call_req_o(creq), .vector_o(vec),
      .call_high_o(chigh), .irq_o(irq));
   core_model i_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .gap_i(gap), .return_from_interrupt_req_i(return_from_interrupt_req),
      .call_req_i(creq), .instr_done_o(done), .return_from_interrupt_o(return_from_interrupt), .call_ack_o(ack));
   task automatic conclude;
      if (err_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // byte write, or single-bit write where only wdata[0] counts
   task automatic wr8(input logic [7:0] a, input logic [7:0] d, input logic bit_mode);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= !bit_mode;
      bw <= bit_mode;
      @(posedge clk_i);
      wr <= 1'b0;
      bw <= 1'b0;
   endtask : wr8
   task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd8
   task automatic pulse(input logic [3:0] e);
      @(posedge clk_i);
      ev <= e;
      @(posedge clk_i);
      ev <= 4'h0;
   endtask : pulse
   // waits for a call, counting boundaries passed first; bounded so a hang ends the run
   task automatic wait_call(input logic [15:0] v, input logic h, output int n_b);
      int n;
      n = 0;
      n_b = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
         n_b += int'(creq !== 1'b1 && done === 1'b1);
      end while (creq !== 1'b1 && n < 200);
      if (n >= 200) begin
         err_count++;
         conclude();
      end
      chk(chigh, h);
      while (creq === 1'b1 && n < 220) begin
         chk(vec, v);
         @(posedge clk_i);
         #1 n++;
      end
      // a call that is never acknowledged ends the run as a failure
      if (n >= 220) begin
         err_count++;
         conclude();
      end
   endtask : wait_call
   task automatic retn;
      int n;
      n = 0;
      @(posedge clk_i);
      return_from_interrupt_req <= 1'b1;
      @(posedge clk_i);
      return_from_interrupt_req <= 1'b0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (!(done === 1'b1 && return_from_interrupt === 1'b1) && n < 100);
      if (n >= 100) begin
         err_count++;
         conclude();
      end
   endtask : retn
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      #1 chk(vec, 16'h0000); // idle vector
      for (i = 0; i < 9; i++) begin
         rd8(ra[i], (ra[i] == 8'hB8) ? 8'h80 : 8'h00);
      end
      wr8(8'hA8, 8'h81, 1'b0);
      rd8(8'hA8, 8'h81);
      wr8(8'hAF, 8'h00, 1'b1);
      rd8(8'hA8, 8'h01); // bit addressable
      wr8(8'hB8, 8'h00, 1'b0);
      rd8(8'hB8, 8'h80);
      wr8(8'hA8, 8'h81, 1'b0);
      wr8(8'hD3, 8'h01, 1'b0);
      pulse(4'h1);
      @(posedge clk_i);
      #1 chk(creq, 1'b0);
      @(posedge clk_i);
      #1 chk(creq, 1'b1);
      wait_call(16'h0003, 1'b0, nb);
      rd8(8'h88, 8'h00);
      rd8(8'hD2, 8'h01);
      chk(irq, 1'b1);
      wr8(8'hD2, 8'h01, 1'b0);
      repeat (2) @(posedge clk_i);
      #1 chk(irq, 1'b0);
      retn();
      wr8(8'hA8, 8'h04, 1'b0);
      pulse(4'h4);
      repeat (12) @(posedge clk_i);
      #1 chk(creq, 1'b0); // global off
      wr8(8'hA8, 8'h84, 1'b0);
      wait_call(16'h0013, 1'b0, nb);
      retn();
      gap <= 4'h3;
      wr8(8'hA8, 8'h8F, 1'b0);
      pulse(4'h6);
      wait_call(16'h000B, 1'b0, nb); // tie order
      repeat (12) @(posedge clk_i);
      #1 chk(creq, 1'b0); // equal level held
      retn();
      wait_call(16'h0013, 1'b0, nb);
      chk(nb, 1);
      retn();
      wr8(8'hB8, 8'h0C, 1'b0);
      pulse(4'h1);
      wait_call(16'h0003, 1'b0, nb);
      pulse(4'h8);
      wait_call(16'h001B, 1'b1, nb); // preempt
      // both levels now active, call and preempt events logged
      rd8(8'hD1, 8'h03);
      rd8(8'hD2, 8'h03);
      pulse(4'h4);
      repeat (12) @(posedge clk_i);
      #1 chk(creq, 1'b0);
      retn();
      wait_call(16'h0013, 1'b1, nb);
      chk(nb, 1);
      retn();
      retn();
      wr8(8'hA8, 8'hFF, 1'b0);
      wr8(8'hE6, 8'hFF, 1'b0);
      wr8(8'hB8, 8'h00, 1'b0);
      for (p = 4; p < 15; p++) begin
         for (s = 0; s < 2; s++) begin
            if (p != 8 && p != 13 && !(s == 1 && (p == 7 || p == 9 || p == 10))) begin
               @(posedge clk_i);
               if (s == 0) prim[p] <= 1'b1;
               else sec[p] <= 1'b1;
               wait_call(16'h0003 + 16'(8 * p), 1'b0, nb);
               @(posedge clk_i);
               prim <= 15'h0;
               sec <= 15'h0;
               retn();
            end
         end
      end
      conclude();
   end
endmodule : tb_top
